// ==== src/efc_pkg.sv ====
package efc_pkg;

    // ****************************************
    // register map
    // ****************************************
    localparam int unsigned ADDR_W = 8;
    localparam logic [ADDR_W-1:0] OFF_MODE = 8'h60;
    localparam logic [ADDR_W-1:0] OFF_CMD = 8'h64;
    localparam logic [ADDR_W-1:0] OFF_STAT = 8'h68;

    // mode register fields
    localparam int unsigned MODE_RDY_IE = 0;
    localparam int unsigned MODE_LOCK_ERROR_FLAG_IE = 2;
    localparam int unsigned MODE_PROGRAMMING_ERROR_FLAG_IE = 3;
    localparam int unsigned MODE_SKIP_ERASE = 7;
    localparam int unsigned FWS_LSB = 8;
    localparam int unsigned FWS_MSB = 9;
    localparam int unsigned TIMING_CYCLE_COUNT_LSB = 16;
    localparam int unsigned TIMING_CYCLE_COUNT_MSB = 23;
    localparam logic [31:0] MODE_WMASK = 32'h00ff038d;
    localparam logic [31:0] MODE_RESET = 32'h00000000;

    // command register fields
    localparam int unsigned KEY_LSB = 24;
    localparam int unsigned KEY_MSB = 31;
    localparam logic [7:0] KEY_VALUE = 8'h5a;
    localparam int unsigned PAGE_LSB = 8;
    localparam int unsigned PAGE_MSB = 17;
    localparam int unsigned CODE_LSB = 0;
    localparam int unsigned CODE_MSB = 3;

    // status register fields
    localparam int unsigned ST_RDY = 0;
    localparam int unsigned ST_LOCK_ERROR_FLAG = 2;
    localparam int unsigned ST_PROGRAMMING_ERROR_FLAG = 3;
    localparam int unsigned ST_SEC = 4;
    localparam int unsigned ST_GP_LSB = 8;
    localparam int unsigned ST_LOCK_LSB = 16;

    // ****************************************
    // array geometry and timing
    // ****************************************
    localparam int unsigned PAGE_W = 10;
    localparam int unsigned NUM_REGIONS = 16;
    localparam int unsigned REGION_LSB = 6;
    localparam int unsigned NUM_GP = 2;
    localparam logic [NUM_REGIONS-1:0] LOCK_RESET = 16'h0000;
    localparam logic [NUM_GP-1:0] GP_RESET = 2'h0;

    // operation lengths in timing ticks (one tick = timing_cycle_count clocks, 0 counting as 1)
    localparam logic [15:0] PAGE_ERASE_TICKS = 16'h0bb8;
    localparam logic [15:0] PAGE_PROG_TICKS = 16'h0bb8;
    localparam logic [15:0] NVM_TICKS = 16'h0bb8;
    localparam logic [15:0] ERASE_ALL_TICKS = 16'h3a98;

    // access lengths in clocks
    localparam logic [2:0] READ_BASE = 3'h1;
    localparam logic [2:0] WRITE_BASE = 3'h2;
    localparam logic [2:0] WRITE_MAX = 3'h4;
    localparam logic [1:0] FWS_TOP = 2'h3;

    // ****************************************
    // types
    // ****************************************
    typedef enum logic [3:0] {
        CMD_NOP = 4'h0,
        CMD_WRITE = 4'h1,
        CMD_LOCK = 4'h2,
        CMD_WRITE_LOCK = 4'h3,
        CMD_UNLOCK = 4'h4,
        CMD_ERASE_ALL = 4'h8,
        CMD_SET_USER = 4'hb,
        CMD_CLR_USER = 4'hd,
        CMD_SET_SECURE = 4'hf
    } efc_cmd_e;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_ERASE = 3'h1,
        ST_PROG = 3'h2,
        ST_NVM = 3'h3,
        ST_ERASE_ALL = 3'h4
    } efc_state_e;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } efc_bus_s;

    typedef struct packed {
        logic start;
        logic [3:0] code;
        logic [PAGE_W-1:0] index;
    } efc_nvm_req_s;

    typedef struct packed {
        logic erase;
        logic prog;
        logic eraseAll;
        logic nvmWrite;
        logic [PAGE_W-1:0] page;
    } efc_flash_s;

endpackage : efc_pkg

// ==== src/efc_timer.sv ====
`timescale 1ns/1ps
// ****************************************
// operation length timer
// ****************************************
module efc_timer
    import efc_pkg::*;
(
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic start,
    input wire logic [15:0] ticks,
    input wire logic [7:0] usCycles,
    output logic done
);

    typedef struct packed {
        logic busy;
        logic [15:0] tickCnt;
        logic [7:0] cycCnt;
        logic done;
    } efc_tmr_s;

    efc_tmr_s st_q;
    efc_tmr_s st_d;
    logic tickEnd;

    // a zero cycle count still ticks every clock, so a slow clock works
    always_comb begin
        st_d = st_q;
        st_d.done = 1'b0;
        tickEnd = (st_q.cycCnt == 8'h00) || (st_q.cycCnt == 8'h01);
        if (start) begin
            st_d.busy = 1'b1;
            st_d.tickCnt = ticks;
            st_d.cycCnt = usCycles;
        end else if (st_q.busy) begin
            if (tickEnd) begin
                st_d.cycCnt = usCycles;
                if (st_q.tickCnt <= 16'h0001) begin
                    st_d.busy = 1'b0;
                    st_d.done = 1'b1;
                end else begin
                    st_d.tickCnt = st_q.tickCnt - 16'h0001;
                end
            end else begin
                st_d.cycCnt = st_q.cycCnt - 8'h01;
            end
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign done = st_q.done;

endmodule : efc_timer

// ==== src/efc_nvm.sv ====
`timescale 1ns/1ps
// ****************************************
// lock, user and security bit store
// ****************************************
module efc_nvm
    import efc_pkg::*;
(
    input wire logic core_clk,
    input wire logic nrst,
    input efc_nvm_req_s req,
    output logic [NUM_REGIONS-1:0] lockBits,
    output logic [NUM_GP-1:0] userBits,
    output logic secure
);

    typedef struct packed {
        logic [NUM_REGIONS-1:0] lock;
        logic [NUM_GP-1:0] user;
        logic sec;
    } efc_nv_s;

    efc_nv_s st_q;
    efc_nv_s st_d;
    logic [3:0] region;
    logic userHit;

    always_comb begin
        st_d = st_q;
        region = req.index[PAGE_W-1:REGION_LSB];
        // an index past the last user bit has no effect
        userHit = (req.index < PAGE_W'(NUM_GP));
        if (req.start) begin
            case (req.code)
                CMD_LOCK,
                CMD_WRITE_LOCK: st_d.lock[region] = 1'b1;
                CMD_UNLOCK: st_d.lock[region] = 1'b0;
                CMD_SET_USER: begin
                    if (userHit) begin
                        st_d.user[req.index[0]] = 1'b1;
                    end
                end
                CMD_CLR_USER: begin
                    if (userHit) begin
                        st_d.user[req.index[0]] = 1'b0;
                    end
                end
                CMD_SET_SECURE: st_d.sec = 1'b1;
                default: st_d = st_q;
            endcase
        end
    end

    // security can only be lifted by a full chip reset here
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            st_q <= {LOCK_RESET, GP_RESET, 1'b0};
        end else begin
            st_q <= st_d;
        end
    end

    assign lockBits = st_q.lock;
    assign userBits = st_q.user;
    assign secure = st_q.sec;

endmodule : efc_nvm

// ==== src/efc_ctrl.sv ====
// Design decision made here: the strobed register port.
`timescale 1ns/1ps
// Function
// - ready raises the interrupt only when mode bit 0 is set
// - lock error raises the interrupt only when mode bit 2 is set
// - programming error raises the interrupt only when mode bit 3 is set
// - skip-erase bit 7 clear erases the page before programming; set skips it
// - wait field 0..3 gives reads of 1..4 and writes of 2,3,4,4 cycles
// - command code 0000 does nothing and sets no programming error
// - code 0001 programs the page in the page field
// - code 0010 locks, 0100 unlocks, the region holding the named page
// - code 0011 programs the page then locks its region
// - code 1000 erases everything, cancelled if any region is locked
// - code 1011 sets, 1101 clears, the user bit indexed by the page field
// - code 1111 sets the security bit; page field ignored here and for erase all
// - undefined codes set programming error and start nothing
// - page field bits 17:8 are read per command; unused bits ignored
// - command acts only when bits 31:24 hold 0x5a, else discarded
// - ready reads 0 while busy, 1 when idle; software waits on it
// - lock error marks a locked-region program attempt, cleared by status read
// - programming error marks a bad code or key written as command
// - each region status bit reads 1 when locked, 0 when unlocked
module efc_ctrl
    import efc_pkg::*;
#(
    parameter logic [15:0] PageEraseTicks = PAGE_ERASE_TICKS,
    parameter logic [15:0] PageProgTicks = PAGE_PROG_TICKS,
    parameter logic [15:0] NvmTicks = NVM_TICKS,
    parameter logic [15:0] EraseAllTicks = ERASE_ALL_TICKS
) (
    input wire logic core_clk,
    input wire logic nrst,
    input efc_bus_s bus,
    output logic [31:0] rdata,
    input wire logic accReq,
    input wire logic accWrite,
    output logic accDone,
    output efc_flash_s flash,
    output logic irq
);

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        efc_state_e st;
        logic [31:0] mode;
        logic lockErr;
        logic progErr;
        logic withLock;
        logic [3:0] code;
        logic [31:0] rdata;
        efc_flash_s flash;
        logic [2:0] accCnt;
        logic accDone;
    } efc_ctl_s;

    efc_ctl_s st_q;
    efc_ctl_s st_d;

    logic tmrStart;
    logic [15:0] tmrTicks;
    logic tmrDone;
    efc_nvm_req_s nvmReq;
    logic [NUM_REGIONS-1:0] lockBits;
    logic [NUM_GP-1:0] userBits;
    logic secure;

    logic cmdWr;
    logic keyOk;
    logic [3:0] code;
    logic [PAGE_W-1:0] page;
    logic pageLocked;
    logic skipErase;
    logic ready;
    logic [1:0] wait_state_count;
    logic [2:0] rdLen;
    logic [2:0] wrLen;
    logic [31:0] status;

    // ****************************************
    // decode
    // ****************************************
    assign cmdWr = bus.wr && (bus.addr == OFF_CMD);
    // a bad key still flags an error, so a dropped write is visible
    assign keyOk = (bus.wdata[KEY_MSB:KEY_LSB] == KEY_VALUE);
    assign code = bus.wdata[CODE_MSB:CODE_LSB];
    assign page = bus.wdata[PAGE_MSB:PAGE_LSB];
    // lock checked at issue only; no region can change while busy
    assign pageLocked = lockBits[page[PAGE_W-1:REGION_LSB]];
    assign skipErase = st_q.mode[MODE_SKIP_ERASE];
    assign ready = (st_q.st == ST_IDLE);
    assign wait_state_count = st_q.mode[FWS_MSB:FWS_LSB];
    assign rdLen = READ_BASE + {1'b0, wait_state_count};
    assign wrLen = (wait_state_count == FWS_TOP) ? WRITE_MAX : (WRITE_BASE + {1'b0, wait_state_count});

    // ****************************************
    // status word
    // ****************************************
    always_comb begin
        status = '0;
        status[ST_RDY] = ready;
        status[ST_LOCK_ERROR_FLAG] = st_q.lockErr;
        status[ST_PROGRAMMING_ERROR_FLAG] = st_q.progErr;
        status[ST_SEC] = secure;
        status[ST_GP_LSB +: NUM_GP] = userBits;
        status[ST_LOCK_LSB +: NUM_REGIONS] = lockBits;
    end

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        st_d = st_q;
        tmrStart = 1'b0;
        tmrTicks = NvmTicks;
        nvmReq = '0;
        nvmReq.code = st_q.code;
        nvmReq.index = st_q.flash.page;

        // ****************************************
        // register bus
        // ****************************************
        // read data stand only in the cycle after the strobe
        st_d.rdata = '0;
        if (bus.rd) begin
            case (bus.addr)
                OFF_MODE: st_d.rdata = st_q.mode;
                OFF_STAT: st_d.rdata = status;
                default: st_d.rdata = '0;
            endcase
        end

        // ****************************************
        // mode register
        // ****************************************
        if (bus.wr && (bus.addr == OFF_MODE)) begin
            st_d.mode = bus.wdata & MODE_WMASK;
        end

        // error flags clear on status read; a same-cycle set below wins
        if (bus.rd && (bus.addr == OFF_STAT)) begin
            st_d.lockErr = 1'b0;
            st_d.progErr = 1'b0;
        end

        // ****************************************
        // command sequencer
        // ****************************************
        case (st_q.st)
            ST_IDLE: begin
                // commands arriving while busy are dropped without an error
                if (cmdWr && !keyOk) begin
                    st_d.progErr = 1'b1;
                end else if (cmdWr) begin
                    st_d.code = code;
                    st_d.flash.page = page;
                    st_d.withLock = (code == CMD_WRITE_LOCK);

                    case (code)
                        CMD_NOP: st_d.st = ST_IDLE;

                        CMD_WRITE,
                        CMD_WRITE_LOCK: begin
                            if (pageLocked) begin
                                st_d.lockErr = 1'b1;
                            end else if (skipErase) begin
                                st_d.st = ST_PROG;
                                st_d.flash.prog = 1'b1;
                                tmrStart = 1'b1;
                                tmrTicks = PageProgTicks;
                            end else begin
                                st_d.st = ST_ERASE;
                                st_d.flash.erase = 1'b1;
                                tmrStart = 1'b1;
                                tmrTicks = PageEraseTicks;
                            end
                        end

                        CMD_LOCK,
                        CMD_UNLOCK,
                        CMD_SET_USER,
                        CMD_CLR_USER,
                        CMD_SET_SECURE: begin
                            st_d.st = ST_NVM;
                            st_d.flash.nvmWrite = 1'b1;
                            tmrStart = 1'b1;
                        end

                        CMD_ERASE_ALL: begin
                            if (|lockBits) begin
                                st_d.lockErr = 1'b1;
                            end else begin
                                st_d.st = ST_ERASE_ALL;
                                st_d.flash.eraseAll = 1'b1;
                                tmrStart = 1'b1;
                                tmrTicks = EraseAllTicks;
                            end
                        end

                        default: st_d.progErr = 1'b1;
                    endcase
                end
            end

            ST_ERASE: begin
                if (tmrDone) begin
                    st_d.st = ST_PROG;
                    st_d.flash.erase = 1'b0;
                    st_d.flash.prog = 1'b1;
                    tmrStart = 1'b1;
                    tmrTicks = PageProgTicks;
                end
            end

            ST_PROG: begin
                if (tmrDone) begin
                    st_d.flash.prog = 1'b0;
                    if (st_q.withLock) begin
                        st_d.st = ST_NVM;
                        st_d.flash.nvmWrite = 1'b1;
                        tmrStart = 1'b1;
                    end else begin
                        st_d.st = ST_IDLE;
                    end
                end
            end

            ST_NVM: begin
                if (tmrDone) begin
                    nvmReq.start = 1'b1;
                    st_d.flash.nvmWrite = 1'b0;
                    st_d.st = ST_IDLE;
                end
            end

            ST_ERASE_ALL: begin
                if (tmrDone) begin
                    st_d.flash.eraseAll = 1'b0;
                    st_d.st = ST_IDLE;
                end
            end

            default: st_d.st = ST_IDLE;
        endcase

        // ****************************************
        // flash access length
        // ****************************************
        // a request during a running access is dropped, not queued
        st_d.accDone = 1'b0;
        if (st_q.accCnt != 3'h0) begin
            st_d.accCnt = st_q.accCnt - 3'h1;
            st_d.accDone = (st_q.accCnt == 3'h1);
        end else if (accReq) begin
            st_d.accCnt = accWrite ? wrLen : rdLen;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            st_q <= '0;
            st_q.st <= ST_IDLE;
            st_q.mode <= MODE_RESET;
        end else begin
            st_q <= st_d;
        end
    end

    // ****************************************
    // sub-blocks
    // ****************************************
    // the timing count steps the operation clock; its correctness is software's
    efc_timer u_timer (
        .core_clk(core_clk),
        .nrst(nrst),
        .start(tmrStart),
        .ticks(tmrTicks),
        .usCycles(st_q.mode[TIMING_CYCLE_COUNT_MSB:TIMING_CYCLE_COUNT_LSB]),
        .done(tmrDone)
    );

    efc_nvm u_nvm (
        .core_clk(core_clk),
        .nrst(nrst),
        .req(nvmReq),
        .lockBits(lockBits),
        .userBits(userBits),
        .secure(secure)
    );

    // ****************************************
    // outputs
    // ****************************************
    assign rdata = st_q.rdata;
    assign accDone = st_q.accDone;
    assign flash = st_q.flash;
    // level irq: it stays up while idle and enabled
    assign irq = (ready && st_q.mode[MODE_RDY_IE])
        || (st_q.lockErr && st_q.mode[MODE_LOCK_ERROR_FLAG_IE])
        || (st_q.progErr && st_q.mode[MODE_PROGRAMMING_ERROR_FLAG_IE]);

endmodule : efc_ctrl

// ==== tb/efc_ctrl_asserts.sv ====
`timescale 1ns/1ps
// ****************************************
// port checker
// ****************************************
module efc_ctrl_asserts
    import efc_pkg::*;
(
    input wire logic core_clk,
    input wire logic nrst,
    input efc_bus_s bus,
    input wire logic [31:0] rdata,
    input wire logic accReq,
    input wire logic accWrite,
    input wire logic accDone,
    input efc_flash_s flash,
    input wire logic irq
);
    logic [31:0] modeQ;
    logic [3:0] codeQ;
    logic [2:0] accQ;
    logic [2:0] accN;
    logic accEnd;
    logic [1:0] wait_state_count;
    logic [3:0] code;
    logic busy;
    logic cmdOk;
    // busy taken from strobes, ready itself is not on the ports
    assign busy = flash.erase | flash.prog | flash.eraseAll | flash.nvmWrite;
    assign code = bus.wdata[CODE_MSB:CODE_LSB];
    assign cmdOk = bus.wr && bus.addr == OFF_CMD && !busy
        && bus.wdata[KEY_MSB:KEY_LSB] == KEY_VALUE;
    assign wait_state_count = modeQ[FWS_MSB:FWS_LSB];
    assign accN = !accWrite ? READ_BASE + 3'(wait_state_count)
        : (wait_state_count == FWS_TOP) ? WRITE_MAX : WRITE_BASE + 3'(wait_state_count);
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            modeQ <= MODE_RESET;
            codeQ <= 4'h0;
            accQ <= 3'h0;
            accEnd <= 1'b0;
        end else begin
            if (bus.wr && bus.addr == OFF_MODE) modeQ <= bus.wdata & MODE_WMASK;
            if (cmdOk) codeQ <= code;
            // done follows the last count by one register stage
            accEnd <= (accQ == 3'h1);
            // a request is only taken once the count is back at zero
            if (accReq && accQ == 3'h0) accQ <= accN;
            else if (accQ != 3'h0) accQ <= accQ - 3'h1;
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);
    sequence s_quiet;
        !busy [*2];
    endsequence
    sequence s_nvmRun;
        flash.nvmWrite && flash.page == $past(bus.wdata[PAGE_MSB:PAGE_LSB]);
    endsequence
    property p_mode_rb;
        bus.rd && bus.addr == OFF_MODE |=> rdata == $past(modeQ);
    endproperty
    property p_irq_off;
        (modeQ & 32'h0000000d) == 32'h0 |-> !irq;
    endproperty
    property p_rdy_irq;
        $past(bus.rd) && $past(bus.addr) == OFF_STAT && rdata[ST_RDY]
            && modeQ[MODE_RDY_IE] |-> irq;
    endproperty
    property p_key_drop;
        bus.wr && bus.addr == OFF_CMD && !busy
            && bus.wdata[KEY_MSB:KEY_LSB] != KEY_VALUE |=> s_quiet;
    endproperty
    property p_nop;
        cmdOk && code == CMD_NOP |=> s_quiet;
    endproperty
    property p_undef;
        cmdOk && !(code inside {4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h8, 4'hb, 4'hd, 4'hf})
            |=> s_quiet;
    endproperty
    property p_erase_first;
        $rose(flash.prog) && !modeQ[MODE_SKIP_ERASE] |-> $past(flash.erase);
    endproperty
    property p_erase_then_prog;
        $fell(flash.erase) |-> flash.prog;
    endproperty
    property p_acc_len;
        accDone == accEnd;
    endproperty
    property p_nvm_start;
        cmdOk && code inside {CMD_LOCK, CMD_UNLOCK, CMD_SET_USER, CMD_CLR_USER}
            |=> s_nvmRun;
    endproperty
    property p_write_lock;
        $fell(flash.prog) && codeQ == CMD_WRITE_LOCK |-> flash.nvmWrite;
    endproperty
    a_mode_rb: assert property (p_mode_rb) else $error("mode readback wrong");
    a_irq_off: assert property (p_irq_off) else $error("irq while masked");
    a_rdy_irq: assert property (p_rdy_irq) else $error("ready irq missing");
    a_key_drop: assert property (p_key_drop) else $error("bad key started op");
    a_nop: assert property (p_nop) else $error("nop started op");
    a_undef: assert property (p_undef) else $error("reserved code started op");
    a_erase_first: assert property (p_erase_first) else $error("no erase");
    a_erase_then_prog: assert property (p_erase_then_prog) else $error("no prog");
    a_acc_len: assert property (p_acc_len) else $error("access length wrong");
    a_nvm_start: assert property (p_nvm_start) else $error("nvm write wrong");
    a_write_lock: assert property (p_write_lock) else $error("no lock after prog");
endmodule : efc_ctrl_asserts

bind efc_ctrl efc_ctrl_asserts i_chk (.core_clk(core_clk), .nrst(nrst), .bus(bus),
    .rdata(rdata), .accReq(accReq), .accWrite(accWrite), .accDone(accDone),
    .flash(flash), .irq(irq));

// ==== tb/tb.sv ====
`timescale 1ns/1ps
// ****************************************
// register level bench
// ****************************************
module tb;
    import efc_pkg::*;
    logic core_clk;
    logic nrst;
    efc_bus_s bus;
    logic [31:0] rdata;
    logic accReq;
    logic accWrite;
    logic accDone;
    efc_flash_s flash;
    logic irq;
    int n_fail;
    int checks;
    int nErase;
    int nProg;
    int nAll;
    // short phases keep the run small
    efc_ctrl #(.PageEraseTicks(16'h0004), .PageProgTicks(16'h0004),
        .NvmTicks(16'h0004), .EraseAllTicks(16'h0004)) i_dut (.core_clk(core_clk),
        .nrst(nrst), .bus(bus), .rdata(rdata), .accReq(accReq), .accWrite(accWrite),
        .accDone(accDone), .flash(flash), .irq(irq));
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        if (flash.erase === 1'b1) nErase++;
        if (flash.prog === 1'b1) nProg++;
        if (flash.eraseAll === 1'b1) nAll++;
    end
    task automatic test_done();
        if (n_fail == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : test_done
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge core_clk);
        bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        @(posedge core_clk);
        bus <= '0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge core_clk);
        bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge core_clk);
        bus <= '0;
        #1;
        v = rdata;
    endtask : rd
    task automatic cmd(input logic [3:0] c, input logic [9:0] p);
        wr(OFF_CMD, {KEY_VALUE, 6'h0, p, 4'h0, c});
    endtask : cmd
    // status reads clear error flags, so only used after clean commands
    task automatic waitRdy();
        logic [31:0] s;
        for (int i = 0; i < 100; i++) begin
            rd(OFF_STAT, s);
            if (s[ST_RDY] === 1'b1) return;
        end
        chk(s, 32'h1);
    endtask : waitRdy
    task automatic acc(input logic w, output int n);
        @(posedge core_clk);
        accReq <= 1'b1;
        accWrite <= w;
        @(posedge core_clk);
        accReq <= 1'b0;
        n = 0;
        #1;
        while (accDone !== 1'b1 && n < 10) begin
            @(posedge core_clk);
            #1;
            n++;
        end
    endtask : acc
    initial begin
        #1000000;
        n_fail++;
        test_done();
    end
    initial begin
        logic [31:0] d;
        logic [3:0] bad[7];
        int e0;
        int p0;
        int n;
        bad = '{4'h5, 4'h6, 4'h7, 4'h9, 4'ha, 4'hc, 4'he};
        nrst = 1'b0;
        bus = '0;
        accReq = 1'b0;
        accWrite = 1'b0;
        n_fail = 0;
        checks = 0;
        repeat (4) @(posedge core_clk);
        nrst <= 1'b1;
        rd(OFF_MODE, d);
        chk(d, MODE_RESET);
        rd(OFF_STAT, d);
        chk(d, 32'h1);
        chk({31'h0, irq}, 32'h0);
        rd(8'h6c, d);
        chk(d, 32'h0);
        wr(OFF_MODE, 32'hffffffff);
        rd(OFF_MODE, d);
        chk(d, MODE_WMASK);
        rd(OFF_STAT, d);
        chk({31'h0, irq}, 32'h1);
        wr(OFF_MODE, 32'h00010000);
        #1;
        chk({31'h0, irq}, 32'h0);
        cmd(CMD_NOP, 10'h3ff);
        rd(OFF_STAT, d);
        chk(d, 32'h1);
        foreach (bad[i]) begin
            cmd(bad[i], 10'h0);
            rd(OFF_STAT, d);
            chk(d, 32'h9);
        end
        e0 = nErase;
        wr(OFF_CMD, 32'ha5000101);
        rd(OFF_STAT, d);
        chk(d, 32'h9);
        chk({31'h0, nErase != e0}, 32'h0);
        wr(OFF_MODE, 32'h00010008);
        cmd(4'h6, 10'h0);
        #1;
        chk({31'h0, irq}, 32'h1);
        rd(OFF_STAT, d);
        chk({31'h0, irq}, 32'h0);
        // page write with and without the erase phase
        for (int sk = 0; sk < 2; sk++) begin
            wr(OFF_MODE, 32'h00010000 | (32'(sk) << MODE_SKIP_ERASE));
            e0 = nErase;
            p0 = nProg;
            cmd(CMD_WRITE, 10'h005);
            #1;
            chk({22'h0, flash.page}, 32'h5);
            rd(OFF_STAT, d);
            chk({31'h0, d[ST_RDY]}, 32'h0);
            waitRdy();
            chk({31'h0, nErase != e0}, 32'(1 - sk));
            chk({31'h0, nProg != p0}, 32'h1);
        end
        wr(OFF_MODE, 32'h00010004);
        cmd(CMD_LOCK, 10'h041);
        waitRdy();
        rd(OFF_STAT, d);
        chk(d, 32'h00020001);
        p0 = nProg;
        cmd(CMD_WRITE, 10'h07f);
        #1;
        chk({31'h0, irq}, 32'h1);
        rd(OFF_STAT, d);
        chk(d, 32'h00020005);
        rd(OFF_STAT, d);
        chk(d, 32'h00020001);
        chk({31'h0, irq}, 32'h0);
        chk({31'h0, nProg != p0}, 32'h0);
        e0 = nAll;
        cmd(CMD_ERASE_ALL, 10'h0);
        rd(OFF_STAT, d);
        chk(d, 32'h00020005);
        chk({31'h0, nAll != e0}, 32'h0);
        cmd(CMD_UNLOCK, 10'h07f);
        waitRdy();
        rd(OFF_STAT, d);
        chk(d, 32'h1);
        cmd(CMD_WRITE_LOCK, 10'h0c0);
        waitRdy();
        rd(OFF_STAT, d);
        chk(d, 32'h00080001);
        cmd(CMD_UNLOCK, 10'h0c0);
        waitRdy();
        cmd(CMD_ERASE_ALL, 10'h3ff);
        waitRdy();
        chk({31'h0, nAll != e0}, 32'h1);
        for (int i = 0; i < 3; i++) begin
            cmd(CMD_SET_USER, 10'(i));
            waitRdy();
        end
        rd(OFF_STAT, d);
        chk(d, 32'h301);
        cmd(CMD_CLR_USER, 10'h001);
        waitRdy();
        cmd(CMD_SET_SECURE, 10'h3ff);
        waitRdy();
        rd(OFF_STAT, d);
        chk(d, 32'h111);
        // access length for every wait setting
        for (int f = 0; f < 4; f++) begin
            wr(OFF_MODE, 32'h00010000 | (32'(f) << FWS_LSB));
            acc(1'b0, n);
            chk(32'(n), 32'(f + 1));
            acc(1'b1, n);
            chk(32'(n), (f == 0) ? 32'h2 : (f == 1) ? 32'h3 : 32'h4);
        end
        test_done();
    end
endmodule : tb
